// File: inc/phy_status_pkg.sv
// Constants, field positions and carrier types for the status summary block
package phy_status_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W    = 5;
  localparam int DATA_W    = 16;
  localparam int NUM_FLAGS = 6;

  // ----------------------------------------------------------------------
  // Management register offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_BASIC_MODE_STATUS   = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_AUTONEG_EXPANSION   = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_STATUS_SUMMARY      = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_INTERRUPT_SOURCE    = 5'h12;
  localparam logic [ADDR_W-1:0] OFS_FALSE_CARRIER_CNT   = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_RECEIVE_ERROR_CNT   = 5'h15;
  localparam logic [ADDR_W-1:0] OFS_TENMEG_STATUS_CTRL  = 5'h1a;

  localparam logic [DATA_W-1:0] SUMMARY_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Field positions in the status summary
  // ----------------------------------------------------------------------
  localparam int BIT_RESERVED      = 15;
  localparam int BIT_MDIX          = 14;
  localparam int BIT_RX_ERROR      = 13;
  localparam int BIT_POLARITY      = 12;
  localparam int BIT_FALSE_CARRIER = 11;
  localparam int BIT_SIGNAL_DETECT = 10;
  localparam int BIT_DESCR_LOCK    = 9;
  localparam int BIT_PAGE_RECEIVED = 8;
  localparam int BIT_IRQ_PENDING   = 7;
  localparam int BIT_REMOTE_FAULT  = 6;
  localparam int BIT_JABBER        = 5;
  localparam int BIT_AN_COMPLETE   = 4;
  localparam int BIT_LOOPBACK      = 3;
  localparam int BIT_DUPLEX        = 2;
  localparam int BIT_SPEED         = 1;
  localparam int BIT_LINK          = 0;

  // ----------------------------------------------------------------------
  // Sticky flag indices
  // ----------------------------------------------------------------------
  localparam int FLAG_RX_ERROR      = 0;
  localparam int FLAG_POLARITY      = 1;
  localparam int FLAG_FALSE_CARRIER = 2;
  localparam int FLAG_PAGE_RECEIVED = 3;
  localparam int FLAG_IRQ_PENDING   = 4;
  localparam int FLAG_REMOTE_FAULT  = 5;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mgmt_req_type;

  typedef struct packed {
    logic mdix_swapped;
    logic signal_detect;
    logic descr_lock;
    logic jabber;
    logic an_complete;
    logic mii_loopback;
    logic full_duplex;
    logic speed_10;
    logic link_up;
  } live_type;

  typedef struct packed {
    logic rx_error;
    logic polarity_inverted;
    logic false_carrier;
    logic page_received;
    logic irq_raise;
    logic remote_fault;
  } event_type;

endpackage

// File: rtl/sticky_flags.sv
// Bank of sticky event flags where a set beats a simultaneous clear
`timescale 1ns/1ps
module sticky_flags #(
  parameter int WIDTH = 6
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] set_pulse,
  input  wire logic [WIDTH-1:0] clr_pulse,
  output logic      [WIDTH-1:0] flag_q
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("sticky_flags needs at least one flag");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------------
  // Set is ORed after the clear so an event in the clearing cycle survives
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flag_q <= '0;
    end else if (ce) begin
      flag_q <= (flag_q & ~clr_pulse) | set_pulse;
    end
  end

endmodule // sticky_flags

// File: rtl/phy_status_summary_reg.sv
// Read-only PHY status summary register with latched event flags
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// --------------------------------------------------------------------------
module phy_status_summary_reg
  import phy_status_pkg::*;
#(
  parameter int DATA_WIDTH = phy_status_pkg::DATA_W
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  input  wire logic                     ce,
  input  wire phy_status_pkg::mgmt_req_type mgmt_req,
  input  wire phy_status_pkg::live_type live_in,
  input  wire phy_status_pkg::event_type events_in,
  output logic                          rd_valid,
  output logic                          rd_hit,
  output logic [DATA_WIDTH-1:0]         rd_data
);

  import phy_status_pkg::*;

  generate
    if (DATA_WIDTH != DATA_W) begin : g_bad_width
      $error("status summary is a 16-bit register");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------
  logic                 rd_take;
  logic                 rd_summary;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [NUM_FLAGS-1:0] flag_q;
  live_type             live_reg;
  logic [DATA_W-1:0]    summary;

  // A cycle that carries a write is never treated as a read
  assign rd_take    = ce & mgmt_req.rd & ~mgmt_req.wr;
  assign rd_summary = rd_take & (mgmt_req.addr == OFS_STATUS_SUMMARY);

  // Clears come from reads of the source registers, never of the summary
  always_comb begin
    flag_clr = '0;
    if (rd_take) begin
      flag_clr[FLAG_RX_ERROR] =
        (mgmt_req.addr == OFS_RECEIVE_ERROR_CNT);
      flag_clr[FLAG_POLARITY] =
        (mgmt_req.addr == OFS_TENMEG_STATUS_CTRL);
      flag_clr[FLAG_FALSE_CARRIER] =
        (mgmt_req.addr == OFS_FALSE_CARRIER_CNT);
      flag_clr[FLAG_PAGE_RECEIVED] =
        (mgmt_req.addr == OFS_AUTONEG_EXPANSION);
      flag_clr[FLAG_IRQ_PENDING] =
        (mgmt_req.addr == OFS_INTERRUPT_SOURCE);
      flag_clr[FLAG_REMOTE_FAULT] =
        (mgmt_req.addr == OFS_BASIC_MODE_STATUS);
    end
  end

  always_comb begin
    flag_set                     = '0;
    flag_set[FLAG_RX_ERROR]      = events_in.rx_error;
    flag_set[FLAG_POLARITY]      = events_in.polarity_inverted;
    flag_set[FLAG_FALSE_CARRIER] = events_in.false_carrier;
    flag_set[FLAG_PAGE_RECEIVED] = events_in.page_received;
    flag_set[FLAG_IRQ_PENDING]   = events_in.irq_raise;
    flag_set[FLAG_REMOTE_FAULT]  = events_in.remote_fault;
  end

  // ----------------------------------------------------------------------
  // Latched flags
  // ----------------------------------------------------------------------
  sticky_flags #(
    .WIDTH     (NUM_FLAGS)
  ) u_flags (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .ce        (ce),
    .set_pulse (flag_set),
    .clr_pulse (flag_clr),
    .flag_q    (flag_q)
  );

  // ----------------------------------------------------------------------
  // Live indications
  // ----------------------------------------------------------------------
  // Sampled once so a read sees one coherent snapshot of all live bits
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      live_reg <= '0;
    end else if (ce) begin
      live_reg <= live_in;
    end
  end

  // ----------------------------------------------------------------------
  // Summary assembly
  // ----------------------------------------------------------------------
  always_comb begin
    summary                    = SUMMARY_RESET;
    summary[BIT_RESERVED]      = 1'b0;
    summary[BIT_MDIX]          = live_reg.mdix_swapped;
    summary[BIT_RX_ERROR]      = flag_q[FLAG_RX_ERROR];
    summary[BIT_POLARITY]      = flag_q[FLAG_POLARITY];
    summary[BIT_FALSE_CARRIER] = flag_q[FLAG_FALSE_CARRIER];
    summary[BIT_SIGNAL_DETECT] = live_reg.signal_detect;
    summary[BIT_DESCR_LOCK]    = live_reg.descr_lock;
    summary[BIT_PAGE_RECEIVED] = flag_q[FLAG_PAGE_RECEIVED];
    summary[BIT_IRQ_PENDING]   = flag_q[FLAG_IRQ_PENDING];
    summary[BIT_REMOTE_FAULT]  = flag_q[FLAG_REMOTE_FAULT];
    summary[BIT_JABBER]        = live_reg.jabber;
    summary[BIT_AN_COMPLETE]   = live_reg.an_complete;
    summary[BIT_LOOPBACK]      = live_reg.mii_loopback;
    summary[BIT_DUPLEX]        = live_reg.full_duplex;
    summary[BIT_SPEED]         = live_reg.speed_10;
    summary[BIT_LINK]          = live_reg.link_up;
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Data of other offsets is owned elsewhere; this block answers zero there
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
      rd_hit   <= 1'b0;
      rd_data  <= SUMMARY_RESET;
    end else if (ce) begin
      rd_valid <= rd_take;
      rd_hit   <= rd_summary;
      if (rd_take) begin
        rd_data <= rd_summary ? summary : SUMMARY_RESET;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  rx_error_latch_a: assert property (
    ce && events_in.rx_error |=> summary[BIT_RX_ERROR]
  ) else $error("receive error event not latched");

  rx_error_clear_a: assert property (
    rd_take && mgmt_req.addr == OFS_RECEIVE_ERROR_CNT
      && !events_in.rx_error |=> !summary[BIT_RX_ERROR]
  ) else $error("receive error flag not cleared by counter read");

  polarity_clear_a: assert property (
    rd_take && mgmt_req.addr == OFS_TENMEG_STATUS_CTRL
      && !events_in.polarity_inverted |=> !summary[BIT_POLARITY]
  ) else $error("polarity flag not cleared by 10M register read");

  summary_no_clear_a: assert property (
    rd_summary && flag_q[FLAG_POLARITY] && flag_q[FLAG_REMOTE_FAULT]
      |=> flag_q[FLAG_POLARITY] && flag_q[FLAG_REMOTE_FAULT]
  ) else $error("summary read cleared a latched flag");

  false_carrier_a: assert property (
    flag_q[FLAG_FALSE_CARRIER] && !(rd_take
      && mgmt_req.addr == OFS_FALSE_CARRIER_CNT)
      |=> flag_q[FLAG_FALSE_CARRIER]
  ) else $error("false carrier flag dropped without counter read");

  page_clear_a: assert property (
    rd_take && mgmt_req.addr == OFS_AUTONEG_EXPANSION
      && !events_in.page_received |=> !flag_q[FLAG_PAGE_RECEIVED]
  ) else $error("page received flag not cleared by expansion read");

  irq_pending_a: assert property (
    ce && events_in.irq_raise |=> summary[BIT_IRQ_PENDING]
      ##1 (summary[BIT_IRQ_PENDING] || $past(flag_clr[FLAG_IRQ_PENDING]))
  ) else $error("interrupt pending flag lost without source read");

  remote_fault_a: assert property (
    rd_take && mgmt_req.addr == OFS_BASIC_MODE_STATUS
      && !events_in.remote_fault |=> !summary[BIT_REMOTE_FAULT]
  ) else $error("remote fault not cleared by basic status read");

  live_mirror_a: assert property (
    ce |=> summary[BIT_LINK] == $past(live_in.link_up)
      && summary[BIT_JABBER] == $past(live_in.jabber)
      && summary[BIT_MDIX] == $past(live_in.mdix_swapped)
  ) else $error("live status bits do not follow their sources");

  speed_duplex_a: assert property (
    ce |=> summary[BIT_SPEED] == $past(live_in.speed_10)
      && summary[BIT_DUPLEX] == $past(live_in.full_duplex)
  ) else $error("speed or duplex bit does not follow resolution");

  read_data_a: assert property (
    rd_summary |=> rd_valid && rd_hit && rd_data == $past(summary)
  ) else $error("summary read returned wrong data");

  reserved_zero_a: assert property (
    rd_data[BIT_RESERVED] == 1'b0
  ) else $error("reserved bit read as one");

  write_ignored_a: assert property (
    ce && mgmt_req.wr |=> !rd_valid && $stable(rd_data)
      && flag_q == ($past(flag_q) | $past(flag_set))
  ) else $error("write changed summary state");

  // Checked on the first edge out of reset; a reset-qualified antecedent
  // would be switched off by the default disable
  reset_zero_a: assert property (
    $rose(rstn) |-> rd_data == SUMMARY_RESET && flag_q == '0
      && live_reg == '0 && !rd_valid && !rd_hit
  ) else $error("state not zero after reset");

  freeze_a: assert property (
    !ce |=> $stable(flag_q) && $stable(rd_data) && $stable(rd_valid)
  ) else $error("state moved while clock enable low");

  // Live bits reach the read data two edges after they are presented
  mdix_read_a: assert property (
    rd_summary && $past(ce) && $past(rstn)
      |=> rd_data[BIT_MDIX] == $past(live_in.mdix_swapped, 2)
  ) else $error("crossover bit does not follow its source");

  signal_detect_a: assert property (
    rd_summary && $past(ce) && $past(rstn)
      |=> rd_data[BIT_SIGNAL_DETECT] == $past(live_in.signal_detect, 2)
  ) else $error("signal detect bit does not follow its source");

  descr_lock_a: assert property (
    rd_summary && $past(ce) && $past(rstn)
      |=> rd_data[BIT_DESCR_LOCK] == $past(live_in.descr_lock, 2)
  ) else $error("descrambler lock bit does not follow its source");

  jabber_read_a: assert property (
    rd_summary && $past(ce) && $past(rstn)
      |=> rd_data[BIT_JABBER] == $past(live_in.jabber, 2)
  ) else $error("jabber bit does not follow its source");

  an_complete_a: assert property (
    rd_summary && $past(ce) && $past(rstn)
      |=> rd_data[BIT_AN_COMPLETE] == $past(live_in.an_complete, 2)
  ) else $error("negotiation bit does not follow its source");

  loopback_read_a: assert property (
    rd_summary && $past(ce) && $past(rstn)
      |=> rd_data[BIT_LOOPBACK] == $past(live_in.mii_loopback, 2)
  ) else $error("loopback bit does not follow its source");

  link_read_a: assert property (
    rd_summary && $past(ce) && $past(rstn)
      |=> rd_data[BIT_LINK] == $past(live_in.link_up, 2)
  ) else $error("link bit does not follow its source");

  polarity_latch_a: assert property (
    ce && events_in.polarity_inverted |=> flag_q[FLAG_POLARITY]
  ) else $error("polarity event not latched");

  carrier_latch_a: assert property (
    ce && events_in.false_carrier |=> summary[BIT_FALSE_CARRIER]
  ) else $error("false carrier event not latched");

  page_latch_a: assert property (
    ce && events_in.page_received |=> flag_q[FLAG_PAGE_RECEIVED]
  ) else $error("page received event not latched");

  remote_latch_a: assert property (
    ce && events_in.remote_fault |=> summary[BIT_REMOTE_FAULT]
  ) else $error("remote fault event not latched");

  carrier_clear_a: assert property (
    rd_take && mgmt_req.addr == OFS_FALSE_CARRIER_CNT
      && !events_in.false_carrier |=> !flag_q[FLAG_FALSE_CARRIER]
  ) else $error("false carrier flag not cleared by counter read");

  irq_clear_a: assert property (
    rd_take && mgmt_req.addr == OFS_INTERRUPT_SOURCE
      && !events_in.irq_raise |=> !summary[BIT_IRQ_PENDING]
  ) else $error("interrupt pending flag not cleared by source read");

  other_offset_a: assert property (
    rd_take && !rd_summary
      |=> rd_valid && !rd_hit && rd_data == SUMMARY_RESET
  ) else $error("read of another offset answered wrongly");

  idle_quiet_a: assert property (
    ce && !rd_take |=> !rd_valid && !rd_hit
  ) else $error("answer without an accepted read");

  summary_keeps_a: assert property (
    rd_summary |=> flag_q == ($past(flag_q) | $past(flag_set))
  ) else $error("summary read disturbed the latched flags");

endmodule // phy_status_summary_reg

// File: verif/tb_phy_status_summary_reg.sv
// Self-checking bench for the status summary register block
`timescale 1ns/1ps
module tb_phy_status_summary_reg;
  import phy_status_pkg::*;

  localparam int CYCLE_LIMIT = 5000;

  logic         ref_clk;
  logic         rstn;
  logic         ce;
  mgmt_req_type mgmt_req;
  live_type     live_in;
  event_type    events_in;
  logic         rd_valid;
  logic         rd_hit;
  logic [15:0]  rd_data;
  logic [16:0]  exp_q[$];
  event_type    flag_m;
  live_type     live_m;
  logic         prev_rd;
  int           miscompares;
  int           comparisons;
  int           cycles;
  logic [4:0]   clr_addr[6];

  phy_status_summary_reg i_phy_status_summary_reg (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .ce        (ce),
    .mgmt_req  (mgmt_req),
    .live_in   (live_in),
    .events_in (events_in),
    .rd_valid  (rd_valid),
    .rd_hit    (rd_hit),
    .rd_data   (rd_data)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------------------------
  // Reference model
  // --------------------------------------------------------------------
  function automatic logic [15:0] summary();
    logic [15:0] s;
    s = 16'h0000;
    s[BIT_MDIX]          = live_m.mdix_swapped;
    s[BIT_RX_ERROR]      = flag_m.rx_error;
    s[BIT_POLARITY]      = flag_m.polarity_inverted;
    s[BIT_FALSE_CARRIER] = flag_m.false_carrier;
    s[BIT_SIGNAL_DETECT] = live_m.signal_detect;
    s[BIT_DESCR_LOCK]    = live_m.descr_lock;
    s[BIT_PAGE_RECEIVED] = flag_m.page_received;
    s[BIT_IRQ_PENDING]   = flag_m.irq_raise;
    s[BIT_REMOTE_FAULT]  = flag_m.remote_fault;
    s[BIT_JABBER]        = live_m.jabber;
    s[BIT_AN_COMPLETE]   = live_m.an_complete;
    s[BIT_LOOPBACK]      = live_m.mii_loopback;
    s[BIT_DUPLEX]        = live_m.full_duplex;
    s[BIT_SPEED]         = live_m.speed_10;
    s[BIT_LINK]          = live_m.link_up;
    return s;
  endfunction

  function automatic live_type rl();
    return live_type'(9'($urandom));
  endfunction

  // One cycle of stimulus; the expected answer is queued as it is issued
  task automatic step(input logic rd, input logic wr, input logic [4:0] a,
                      input live_type lv, input event_type ev,
                      input logic c);
    logic      acc;
    event_type clr;
    @(negedge ref_clk);
    ce        = c;
    mgmt_req  = '{rd, wr, a, 16'($urandom)};
    live_in   = lv;
    events_in = ev;
    acc = c && rd && !wr;
    clr = '0;
    if (acc) begin
      exp_q.push_back((a == OFS_STATUS_SUMMARY) ?
                      {1'b1, summary()} : 17'h00000);
      clr.rx_error          = (a == OFS_RECEIVE_ERROR_CNT);
      clr.polarity_inverted = (a == OFS_TENMEG_STATUS_CTRL);
      clr.false_carrier     = (a == OFS_FALSE_CARRIER_CNT);
      clr.page_received     = (a == OFS_AUTONEG_EXPANSION);
      clr.irq_raise         = (a == OFS_INTERRUPT_SOURCE);
      clr.remote_fault      = (a == OFS_BASIC_MODE_STATUS);
    end
    if (c) begin
      flag_m = (flag_m & ~clr) | ev;
      live_m = lv;
    end
    prev_rd = acc;
  endtask

  task automatic do_reset();
    @(negedge ref_clk);
    rstn      = 1'b0;
    ce        = 1'b1;
    mgmt_req  = '0;
    live_in   = '0;
    events_in = '0;
    repeat (4) @(negedge ref_clk);
    rstn    = 1'b1;
    flag_m  = '0;
    live_m  = '0;
    prev_rd = 1'b0;
  endtask

  task automatic report(input string msg);
    miscompares++;
    $display("Error at %0t: %s", $time, msg);
  endtask

  task automatic finish_test();
    if (exp_q.size() != 0)
      report("answers missing");
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Monitor: answers must appear exactly one edge after the read
  // --------------------------------------------------------------------
  initial begin
    forever begin
      @(posedge ref_clk);
      #1;
      if (exp_q.size() != 0) begin
        comparisons++;
        if (rd_valid !== 1'b1)
          report("no answer to read");
        else if ({rd_hit, rd_data} !== exp_q[0])
          report($sformatf("got %h exp %h", {rd_hit, rd_data}, exp_q[0]));
        void'(exp_q.pop_front());
      end else if (rd_valid === 1'b1) begin
        report("answer without read");
      end
    end
  end

  // Cuts a hang short
  initial begin
    cycles = 0;
    forever begin
      @(posedge ref_clk);
      cycles++;
      if (cycles == CYCLE_LIMIT) begin
        report("timeout");
        finish_test();
      end
    end
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    mgmt_req = '0;
    live_in = '0;
    events_in = '0;
    miscompares = 0;
    comparisons = 0;
    clr_addr = '{OFS_RECEIVE_ERROR_CNT, OFS_TENMEG_STATUS_CTRL,
                 OFS_FALSE_CARRIER_CNT, OFS_AUTONEG_EXPANSION,
                 OFS_INTERRUPT_SOURCE, OFS_BASIC_MODE_STATUS};
    void'($urandom(35806));
    do_reset();
    step(1, 0, OFS_STATUS_SUMMARY, '0, '0, 1);
    step(1, 0, 5'h03, '0, '0, 1);
    $display("Test reset values done");
    // Each clearing read, a summary write and a set racing a clear
    for (int i = 0; i < 6; i++) begin
      step(0, 0, 5'h00, rl(), event_type'(6'h3f), 1);
      step(1, 0, OFS_STATUS_SUMMARY, rl(), '0, 1);
      step(0, 1, OFS_STATUS_SUMMARY, rl(), '0, 1);
      step(1, 0, OFS_STATUS_SUMMARY, rl(), '0, 1);
      step(1, 0, clr_addr[i], rl(), '0, 1);
      step(1, 0, OFS_STATUS_SUMMARY, rl(), '0, 1);
      step(1, 0, clr_addr[i], rl(), event_type'(6'h3f), 1);
      step(1, 1, clr_addr[i], rl(), '0, 1);
      step(1, 0, OFS_STATUS_SUMMARY, rl(), '0, 1);
    end
    $display("Test clearing reads done");
    // Random traffic; clock enable only drops when no answer is due
    for (int n = 0; n < 1500; n++) begin
      logic [4:0] a;
      a = ($urandom % 3 == 0) ? 5'($urandom) :
          (($urandom % 2) ? OFS_STATUS_SUMMARY : clr_addr[$urandom % 6]);
      step(1'($urandom), ($urandom % 5) == 0, a, rl(),
           event_type'(6'($urandom & $urandom & $urandom)),
           prev_rd || ($urandom % 6) != 0);
    end
    $display("Test random traffic done");
    // Reset in mid-run wipes latched flags and live bits
    step(0, 0, 5'h00, live_type'(9'h1ff), event_type'(6'h3f), 1);
    step(0, 0, 5'h00, live_type'(9'h1ff), '0, 1);
    do_reset();
    step(1, 0, OFS_STATUS_SUMMARY, '0, '0, 1);
    step(0, 0, 5'h00, '0, '0, 1);
    $display("Test second reset done");
    repeat (3) @(negedge ref_clk);
    finish_test();
  end
endmodule // tb_phy_status_summary_reg
